// >>> logic/adp_port.sv
`timescale 1ns/1ps
// Overview of operation
// - with the test pin at ground the counter freezes and all its outputs go high.
// - on the first clock after the test pin leaves ground all counter outputs go low.
// - with the test pin at mid level the output latch follows the live counter.
// - a full-scale reading is 4096 counts, beyond which overrange is flagged.
// - with chip enable tied low each byte drives only while its own enable is low.
// - a byte drives only when chip enable and that byte's enable are both low.
// - with mode low, chip enable with both byte enables low drives all 14 data pins.
// - a converter whose chip enable is high keeps all its data pins released.
// - status falls from high to low when a conversion ends with new data.
// - conversions start only while run/hold is high; while it is low none starts, but one under way runs to its end.
// - with mode low and every enable held low the data pins stay driven continuously.
// - enable pins are inputs only while mode is low; otherwise they are outputs.
// - upper byte holds result bits 9-12, sign and overrange; lower byte 1-8.
module adp_port (
  input wire logic clk,
  input wire logic resetn,
  // converter front end, same clock
  input wire logic zero_cross,
  input wire logic input_negative,
  // pins
  input wire logic run_hold,
  input wire logic mode,
  input wire logic send,
  input wire logic [1:0] test_level,
  input wire logic chip_enable_n_i,
  input wire logic upper_byte_enable_n_i,
  input wire logic lower_byte_enable_n_i,
  output logic chip_enable_n_o,
  output logic upper_byte_enable_n_o,
  output logic lower_byte_enable_n_o,
  output logic enable_oe_n,
  output logic [13:0] data_o,
  output logic upper_oe_n,
  output logic lower_oe_n,
  output logic status,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);

  logic [2:0] en_n_s;
  logic [1:0] test_s;
  logic run_s;
  logic mode_s;
  logic send_s;
  logic ce_n;
  logic hb_n;
  logic lb_n;
  logic test_gnd;
  logic test_mid;
  logic test_gnd_prev_q;
  adp_pkg::adp_state_t state_q;
  logic [adp_pkg::CNT_W-1:0] count_q;
  logic sign_q;
  logic finish;
  logic over;
  logic [13:0] latch_q;
  logic status_q;
  logic ctrl_run_q;
  logic [adp_pkg::EV_W-1:0] ev_q;
  logic [adp_pkg::EV_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic [2:0] en_o_q;
  logic en_oe_n_q;
  logic upper_oe_n_q;
  logic lower_oe_n_q;

  // all pins come from outside the clock domain
  adp_pin_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_en_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({chip_enable_n_i, upper_byte_enable_n_i, lower_byte_enable_n_i}),
    .value(en_n_s)
  );
  // reset to test=V+, run low, mode low, send high
  adp_pin_sync #(.WIDTH(5), .RST_VAL(5'h11)) u_ctl_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({test_level, run_hold, mode, send}),
    .value({test_s, run_s, mode_s, send_s})
  );

  assign ce_n = en_n_s[2];
  assign hb_n = en_n_s[1];
  assign lb_n = en_n_s[0];
  assign test_gnd = (test_s == adp_pkg::TEST_GND);
  assign test_mid = (test_s == adp_pkg::TEST_MID);

  // deintegration ends on zero crossing or when full scale is reached
  assign over = (count_q == adp_pkg::CNT_W'(adp_pkg::FULL_SCALE - 1));
  assign finish = (state_q == adp_pkg::ADP_DEINT) && (zero_cross || over);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      test_gnd_prev_q <= 1'b0;
    end else begin
      test_gnd_prev_q <= test_gnd;
    end
  end

  // conversion sequencer; test at ground freezes it like a stopped clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= adp_pkg::ADP_IDLE;
    end else if (test_gnd) begin
      state_q <= state_q;
    end else begin
      unique case (state_q)
        adp_pkg::ADP_IDLE: begin
          if (run_s && ctrl_run_q) begin
            state_q <= adp_pkg::ADP_INTEG;
          end
        end
        adp_pkg::ADP_INTEG: begin
          if (count_q == adp_pkg::CNT_W'(adp_pkg::INT_COUNTS - 1)) begin
            state_q <= adp_pkg::ADP_DEINT;
          end
        end
        adp_pkg::ADP_DEINT: begin
          if (finish) begin
            state_q <= adp_pkg::ADP_IDLE;
          end
        end
      endcase
    end
  end

  // counter with test forcing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (test_gnd) begin
      count_q <= '1;
    end else if (test_gnd_prev_q) begin
      count_q <= '0;
    end else if (state_q == adp_pkg::ADP_IDLE || finish) begin
      count_q <= '0;
    end else if (state_q == adp_pkg::ADP_INTEG &&
                 count_q == adp_pkg::CNT_W'(adp_pkg::INT_COUNTS - 1)) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  // polarity taken from the front end at end of integration
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sign_q <= 1'b0;
    end else if (state_q == adp_pkg::ADP_INTEG && !test_gnd) begin
      sign_q <= input_negative;
    end
  end

  // output latch: loads at conversion end, transparent at mid test level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_q <= adp_pkg::LATCH_RST;
    end else if (test_gnd) begin
      latch_q <= '1;
    end else if (test_gnd_prev_q) begin
      latch_q <= '0;
    end else if (test_mid) begin
      latch_q <= {1'b0, sign_q, count_q[adp_pkg::MAG_W-1:0]};
    end else if (finish) begin
      latch_q <= {over, sign_q, count_q[adp_pkg::MAG_W-1:0]};
    end
  end

  // status high through a conversion, falls when data is new
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q <= 1'b0;
    end else if (finish && !test_gnd) begin
      status_q <= 1'b0;
    end else if (state_q != adp_pkg::ADP_IDLE) begin
      status_q <= 1'b1;
    end
  end

  // enable pins turn to outputs, held inactive, whenever mode is high;
  // the handshake sequence itself is not built here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_o_q <= 3'h7;
      en_oe_n_q <= 1'b1;
    end else begin
      en_o_q <= 3'h7;
      en_oe_n_q <= !mode_s;
    end
  end

  // byte drivers: send is assumed high in direct mode and not consulted
  always_ff @(posedge clk) begin
    if (!resetn) begin
      upper_oe_n_q <= 1'b1;
      lower_oe_n_q <= 1'b1;
    end else begin
      upper_oe_n_q <= ce_n || hb_n || mode_s;
      lower_oe_n_q <= ce_n || lb_n || mode_s;
    end
  end

  // software run gate, reset so that run/hold alone controls conversions
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_run_q <= adp_pkg::CTRL_RUN_RST;
      mask_q <= adp_pkg::IRQ_MASK_RST;
    end else if (wr && addr == adp_pkg::CTRL_OFS) begin
      ctrl_run_q <= wdata[adp_pkg::CTRL_RUN_POS];
    end else if (wr && addr == adp_pkg::IRQ_MASK_OFS) begin
      mask_q <= wdata[adp_pkg::EV_W-1:0];
    end
  end

  // sticky events; a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_q & ~((wr && addr == adp_pkg::IRQ_STAT_OFS) ?
                        wdata[adp_pkg::EV_W-1:0] : 2'h0)) |
              {finish && over && !test_gnd, finish && !test_gnd};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ev_q & mask_q);
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        adp_pkg::CTRL_OFS: rdata_q <= {31'h0, ctrl_run_q};
        adp_pkg::IRQ_STAT_OFS: rdata_q <= {30'h0, ev_q};
        adp_pkg::IRQ_MASK_OFS: rdata_q <= {30'h0, mask_q};
        adp_pkg::RESULT_OFS: rdata_q <= {18'h0, latch_q};
        adp_pkg::STATE_OFS: rdata_q <= {25'h0, send_s, test_s,
                                        state_q, status_q, run_s};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign data_o = latch_q;
  assign upper_oe_n = upper_oe_n_q;
  assign lower_oe_n = lower_oe_n_q;
  assign chip_enable_n_o = en_o_q[2];
  assign upper_byte_enable_n_o = en_o_q[1];
  assign lower_byte_enable_n_o = en_o_q[0];
  assign enable_oe_n = en_oe_n_q;
  assign status = status_q;
  assign rdata = rdata_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  test_force_high_a: assert property (
    test_gnd |=> (count_q == '1) && (latch_q == 14'h3FFF) &&
                 $stable(state_q))
    else $error("test ground did not force counter high");

  test_clear_low_a: assert property (
    $fell(test_gnd) |=> (count_q == '0) && (latch_q == 14'h0000))
    else $error("leaving test ground did not clear counter");

  latch_transparent_a: assert property (
    (test_mid && !test_gnd_prev_q) |=>
      latch_q[11:0] == $past(count_q[11:0]))
    else $error("latch not transparent at mid test level");

  full_scale_a: assert property (
    (state_q == adp_pkg::ADP_DEINT && !test_gnd &&
     count_q == 13'h0FFF && !test_gnd_prev_q && !test_mid) |=>
      latch_q[adp_pkg::OVR_POS] && state_q == adp_pkg::ADP_IDLE)
    else $error("overrange not flagged at full scale");

  byte_drive_a: assert property (
    (!ce_n && !mode_s) |=> (upper_oe_n_q == $past(hb_n)) &&
                           (lower_oe_n_q == $past(lb_n)))
    else $error("byte enable did not gate its byte");

  both_bytes_a: assert property (
    (!ce_n && !hb_n && !lb_n && !mode_s)[*2] |=>
      !upper_oe_n_q && !lower_oe_n_q)
    else $error("not all 14 outputs driven");

  deselect_release_a: assert property (
    ce_n |=> upper_oe_n_q && lower_oe_n_q)
    else $error("deselected converter drives the bus");

  status_fall_a: assert property (
    (finish && !test_gnd && status_q) |=> !status_q ##0 $fell(status_q))
    else $error("status did not fall at conversion end");

  run_hold_a: assert property (
    (state_q == adp_pkg::ADP_IDLE && !run_s) |=>
      state_q == adp_pkg::ADP_IDLE)
    else $error("conversion started while held");

  enable_dir_a: assert property (
    mode_s |=> !en_oe_n_q ##1 (en_oe_n_q == !$past(mode_s)))
    else $error("enable pin direction wrong");

  conv_done_c: cover property (
    state_q == adp_pkg::ADP_DEINT ##1 $fell(status_q));
  overrange_c: cover property (finish && over);
  test_cycle_c: cover property ($rose(test_gnd) ##[1:20] $fell(test_gnd));
  both_read_c: cover property (!upper_oe_n_q && !lower_oe_n_q);

endmodule

// >>> common/adp_pkg.sv
package adp_pkg;

  // result layout on the 14 data pins
  localparam int MAG_W = 12;
  localparam int DATA_W = 14;
  localparam int LO_W = 8;
  localparam int HI_LSB = 8;
  localparam int SIGN_POS = 12;
  localparam int OVR_POS = 13;

  // converter counts
  localparam int INT_COUNTS = 2048;
  localparam int FULL_SCALE = 4096;
  localparam int CNT_W = 13;

  // counter test pin level codes
  localparam logic [1:0] TEST_GND = 2'h0;
  localparam logic [1:0] TEST_MID = 2'h1;
  localparam logic [1:0] TEST_VPLUS = 2'h2;

  // register port
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] RESULT_OFS = 8'h0C;
  localparam logic [7:0] STATE_OFS = 8'h10;

  // field positions
  localparam int CTRL_RUN_POS = 0;
  localparam int EV_DONE_POS = 0;
  localparam int EV_OVR_POS = 1;
  localparam int EV_W = 2;

  // reset values
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [13:0] LATCH_RST = 14'h0000;

  typedef enum logic [1:0] {
    ADP_IDLE,
    ADP_INTEG,
    ADP_DEINT
  } adp_state_t;

endpackage

// >>> logic/adp_pin_sync.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a bit changes once stages two and three agree
module adp_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] value_q;

  // s1 is read only by s2, so metastability never reaches the filter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!resetn) begin
          value_q[i] <= RST_VAL[i];
        end else if (s2_q[i] == s3_q[i]) begin
          value_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign value = value_q;

endmodule

// >>> dv/adp_host_model.sv
`timescale 1ns/1ps
// host side of the byte bus; a released byte toggles each cycle, showing its last data every other cycle
module adp_host_model (
  input wire logic clk,
  input wire logic [13:0] data_o,
  input wire logic upper_oe_n,
  input wire logic lower_oe_n,
  output logic [13:0] bus,
  output logic send
);
  logic [13:0] last_q;
  // direct mode only: no handshake partner, so send is tied high
  assign send = 1'b1;
  // toggling pattern on a released byte, since nothing pulls the lines
  always_ff @(posedge clk) begin
    last_q <= bus;
  end
  assign bus[13:8] = upper_oe_n ? ~last_q[13:8] : data_o[13:8];
  assign bus[7:0] = lower_oe_n ? ~last_q[7:0] : data_o[7:0];
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, resetn, zero_cross, input_negative, run_hold, mode, wr, rd;
  logic ce_n, ub_n, lb_n;
  logic [1:0] test_level;
  logic [7:0] addr;
  logic [31:0] wdata, d;
  wire logic ce_o, ub_o, lb_o, en_oe_n, up_oe_n, lo_oe_n, status, irq, send;
  wire logic [13:0] data_o, bus;
  wire logic [31:0] rdata;
  int n_fail, samples_checked, i;

  adp_port uut (.clk(clk), .resetn(resetn), .zero_cross(zero_cross),
    .input_negative(input_negative), .run_hold(run_hold), .mode(mode),
    .send(send), .test_level(test_level), .chip_enable_n_i(ce_n),
    .upper_byte_enable_n_i(ub_n), .lower_byte_enable_n_i(lb_n),
    .chip_enable_n_o(ce_o), .upper_byte_enable_n_o(ub_o),
    .lower_byte_enable_n_o(lb_o), .enable_oe_n(en_oe_n), .data_o(data_o),
    .upper_oe_n(up_oe_n), .lower_oe_n(lo_oe_n), .status(status),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  adp_host_model host (.clk(clk), .data_o(data_o), .upper_oe_n(up_oe_n),
    .lower_oe_n(lo_oe_n), .bus(bus), .send(send));

  // free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_status(input logic lvl);
    for (int k = 0; k < 9000 && status !== lvl; k++) cyc(1);
    if (status !== lvl) begin
      n_fail++;
      $display("BAD t=%0t status wait timed out", $time);
      report_and_stop();
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic t_reset;
    chk({up_oe_n, lo_oe_n, en_oe_n, status, irq}, 5'h1C);
    chk(data_o, 14'h0000);
    rd_reg(8'h00, d);
    chk(d, 32'h1);
    rd_reg(8'h08, d);
    chk(d, 32'h0);
    rd_reg(8'hFC, d);
    chk(d, 32'h0);
    $display("test reset done");
  endtask

  // every mode and enable combination, active-low enables
  task automatic t_enables;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      {mode, ce_n, ub_n, lb_n} <= i[3:0];
      cyc(8);
      chk(up_oe_n, i[3] | i[2] | i[1]);
      chk(lo_oe_n, i[3] | i[2] | i[0]);
      chk(en_oe_n, !i[3]);
      chk({ce_o, ub_o, lb_o}, 3'h7);
    end
    // back to direct mode, all enables released, for the later tests
    @(posedge clk);
    {mode, ce_n, ub_n, lb_n} <= 4'h7;
    cyc(8);
    $display("test enables done");
  endtask

  task automatic t_test_pin;
    @(posedge clk);
    test_level <= 2'h0;
    cyc(8);
    chk(data_o, 14'h3FFF);
    @(posedge clk);
    test_level <= 2'h2;
    cyc(8);
    chk(data_o, 14'h0000);
    $display("test counter pin done");
  endtask

  // one conversion; zc < 0 means no zero crossing, so it overranges
  task automatic t_conv(input logic neg, input int zc);
    logic [13:0] a;
    @(posedge clk);
    run_hold <= 1'b1;
    input_negative <= neg;
    test_level <= (zc < 0) ? 2'h2 : 2'h1;
    wait_status(1'b1);
    @(posedge clk);
    run_hold <= 1'b0;
    if (zc >= 0) begin
      cyc(2048 + zc - 20);
      a = data_o;
      cyc(10);
      chk(a !== data_o && data_o[13] === 1'b0, 1'b1);
      chk(data_o[11:0], a[11:0] + 12'h00A);
      // leave mid level first, or the latch keeps following the counter
      @(posedge clk);
      test_level <= 2'h2;
      cyc(8);
      @(posedge clk);
      zero_cross <= 1'b1;
    end
    wait_status(1'b0);
    @(posedge clk);
    zero_cross <= 1'b0;
    test_level <= 2'h2;
    ce_n <= 1'b0;
    ub_n <= 1'b0;
    lb_n <= 1'b0;
    cyc(8);
    if (zc < 0) chk(data_o, {2'b10, 12'hFFF});
    else chk(data_o[13:12] === {1'b0, neg} && data_o[11:0] > zc - 4
      && data_o[11:0] < zc + 4, 1'b1);
    chk(bus, data_o);
    rd_reg(8'h0C, d);
    chk(d, {18'h0, data_o});
    chk(irq, 1'b0);
    wr_reg(8'h08, 32'h3);
    cyc(3);
    chk(irq, 1'b1);
    rd_reg(8'h04, d);
    chk(d[1:0], {zc < 0, 1'b1});
    wr_reg(8'h04, 32'h3);
    cyc(3);
    chk(irq, 1'b0);
    rd_reg(8'h04, d);
    chk(d, 32'h0);
    // mask off again so the next conversion starts with irq low
    wr_reg(8'h08, 32'h0);
    cyc(50);
    chk(status, 1'b0);
    $display("test conversion done");
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    resetn = 1'b0;
    zero_cross = 1'b0;
    input_negative = 1'b0;
    run_hold = 1'b0;
    mode = 1'b0;
    ce_n = 1'b1;
    ub_n = 1'b1;
    lb_n = 1'b1;
    test_level = 2'h2;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    cyc(6);
    t_reset();
    t_enables();
    t_test_pin();
    t_conv(1'b1, 300);
    t_conv(1'b0, -1);
    report_and_stop();
  end
endmodule
